// ### logic/slc_switch_lock.sv
`timescale 1ns/1ps
module slc_switch_lock #(
   parameter int NUM_DN = slc_pkg::NUM_DN
) (
   input  wire logic                        clk_sys,
   input  wire logic                        srst,
   slc_link_if.sw                           lk,
   input  wire logic [NUM_DN-1:0]           us_posted_pend,
   input  wire logic [NUM_DN-1:0]           ds_posted_pend,
   output logic                             fwd_valid,
   input  wire logic                        fwd_ready,
   output slc_pkg::slc_req_t                fwd_type,
   output logic [slc_pkg::PORT_W-1:0]       fwd_port,
   input  wire logic                        ds_cpl_valid,
   output logic                             ds_cpl_ready,
   input  wire slc_pkg::slc_cpl_t           ds_cpl_type,
   input  wire logic [slc_pkg::PORT_W-1:0]  ds_cpl_port,
   output logic [NUM_DN-1:0]                blk_dn_port,
   output logic                             blk_to_up,
   output logic                             up_lock_held,
   output logic [slc_pkg::PORT_W-1:0]       locked_port,
   output logic                             switch_locked_flag
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      slc_pkg::slc_st_t             st;
      logic [slc_pkg::PORT_W-1:0]   lock_port;
      logic                         dn_ready;
      logic                         rq_valid;
      slc_pkg::slc_req_t            rq_type;
      logic [slc_pkg::PORT_W-1:0]   rq_port;
      logic                         fwd_valid;
      slc_pkg::slc_req_t            fwd_type;
      logic [slc_pkg::PORT_W-1:0]   fwd_port;
      logic                         cpl_ready;
      logic                         cq_valid;
      slc_pkg::slc_cpl_t            cq_type;
      logic [slc_pkg::PORT_W-1:0]   cq_port;
      logic                         up_valid;
      slc_pkg::slc_cpl_t            up_type;
      logic [slc_pkg::PORT_W-1:0]   up_port;
      logic [NUM_DN-1:0]            blk_dn;
      logic                         blk_up;
      logic                         locked_flag;
   } slc_dev_t;

   slc_dev_t  state_reg;
   slc_dev_t  state_next;
   logic      rq_take;
   logic      cq_take;
   logic      fwd_free;
   logic      up_free;

   logic [NUM_DN-1:0]  rq_post_hit;
   logic [NUM_DN-1:0]  cq_post_hit;

   // ----------------------------------------------------------------
   // Handshake terms
   // ----------------------------------------------------------------
   assign rq_take  = lk.dn_valid && state_reg.dn_ready;
   assign cq_take  = ds_cpl_valid && state_reg.cpl_ready;
   assign fwd_free = !state_reg.fwd_valid || fwd_ready;
   assign up_free  = !state_reg.up_valid || lk.up_ready;

   // ----------------------------------------------------------------
   // Posted-pending bit of the port a held request or completion names
   // ----------------------------------------------------------------
   // A port index beyond the last port matches no bit and waits on nothing
   for (genvar g = 0; g < NUM_DN; g++) begin : g_post
      assign rq_post_hit[g] = us_posted_pend[g] &&
                              (state_reg.rq_port == slc_pkg::PORT_W'(g));
      assign cq_post_hit[g] = ds_posted_pend[g] &&
                              (state_reg.cq_port == slc_pkg::PORT_W'(g));
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;

      // Retire transfers taken by the far side
      if (state_reg.fwd_valid && fwd_ready) begin
         state_next.fwd_valid = 1'b0;
      end
      if (state_reg.up_valid && lk.up_ready) begin
         state_next.up_valid = 1'b0;
      end

      // Capture a request from the root
      if (rq_take) begin
         state_next.rq_valid = 1'b1;
         state_next.rq_type  = lk.dn_type;
         state_next.rq_port  = lk.dn_port;
      end

      // Issue a held request toward the downstream ports
      if (state_reg.rq_valid && fwd_free) begin
         case (state_reg.rq_type)
            slc_pkg::SLC_MRDLK: begin
               if (!(|rq_post_hit)) begin
                  state_next.rq_valid  = 1'b0;
                  state_next.fwd_valid = 1'b1;
                  state_next.fwd_type  = state_reg.rq_type;
                  state_next.fwd_port  = state_reg.rq_port;
                  if (state_reg.st == slc_pkg::SLC_ST_IDLE) begin
                     state_next.st        = slc_pkg::SLC_ST_DNLOCK;
                     state_next.lock_port = state_reg.rq_port;
                  end
                  // A repeat MRdLk leaves the lock as it is
               end
            end
            slc_pkg::SLC_UNLOCK: begin
               if (us_posted_pend == '0) begin
                  state_next.rq_valid  = 1'b0;
                  state_next.fwd_valid = 1'b1;
                  state_next.fwd_type  = state_reg.rq_type;
                  if (state_reg.st != slc_pkg::SLC_ST_IDLE) begin
                     state_next.fwd_port = state_reg.lock_port;
                  end else begin
                     state_next.fwd_port = state_reg.rq_port;
                  end
                  state_next.st        = slc_pkg::SLC_ST_IDLE;
                  state_next.lock_port = slc_pkg::LOCK_PORT_RST;
               end
            end
            default: begin
               // MWr and other requests pass with no state change
               state_next.rq_valid  = 1'b0;
               state_next.fwd_valid = 1'b1;
               state_next.fwd_type  = state_reg.rq_type;
               state_next.fwd_port  = state_reg.rq_port;
            end
         endcase
      end

      // Capture a completion from a downstream port
      if (cq_take) begin
         state_next.cq_valid = 1'b1;
         state_next.cq_type  = ds_cpl_type;
         state_next.cq_port  = ds_cpl_port;
      end

      // Send a held completion upstream
      if (state_reg.cq_valid && up_free &&
          (state_reg.cq_type != slc_pkg::SLC_CPLDLK ||
           !(|cq_post_hit))) begin
         state_next.cq_valid = 1'b0;
         state_next.up_valid = 1'b1;
         state_next.up_type  = state_reg.cq_type;
         state_next.up_port  = state_reg.cq_port;
         if (state_reg.st == slc_pkg::SLC_ST_DNLOCK &&
             state_reg.cq_port == state_reg.lock_port) begin
            if (state_reg.cq_type == slc_pkg::SLC_CPLDLK) begin
               state_next.st = slc_pkg::SLC_ST_SWLOCK;
            end else if (state_reg.cq_type == slc_pkg::SLC_CPLLK) begin
               state_next.st = slc_pkg::SLC_ST_FAIL;
            end
         end
         // Completions in a held lock change nothing
      end

      state_next.dn_ready  = !state_next.rq_valid;
      state_next.cpl_ready = !state_next.cq_valid;

      // Blocking masks; held TLPs wait in the core queues
      // Masks cover forwarded TLPs only, inserted messages pass
      for (int i = 0; i < NUM_DN; i++) begin
         state_next.blk_dn[i] = (state_next.st != slc_pkg::SLC_ST_IDLE) &&
                                (state_next.lock_port == slc_pkg::PORT_W'(i));
      end
      state_next.blk_up = (state_next.st == slc_pkg::SLC_ST_SWLOCK) ||
                          (state_next.st == slc_pkg::SLC_ST_FAIL);

      // Live flag for the status register, readable during lock
      state_next.locked_flag = (state_next.st == slc_pkg::SLC_ST_SWLOCK);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_reg    <= '0;
         state_reg.st <= slc_pkg::SLC_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign lk.dn_ready          = state_reg.dn_ready;
   assign lk.up_valid          = state_reg.up_valid;
   assign lk.up_type           = state_reg.up_type;
   assign lk.up_port           = state_reg.up_port;
   assign fwd_valid            = state_reg.fwd_valid;
   assign fwd_type             = state_reg.fwd_type;
   assign fwd_port             = state_reg.fwd_port;
   assign ds_cpl_ready         = state_reg.cpl_ready;
   assign blk_dn_port          = state_reg.blk_dn;
   assign blk_to_up            = state_reg.blk_up;
   assign up_lock_held         = state_reg.blk_up;
   assign locked_port          = state_reg.lock_port;
   assign switch_locked_flag   = state_reg.locked_flag;

endmodule // slc_switch_lock

// ### logic/slc_pkg.sv
// Functional notes
// - Only one locked sequence at a time.
// - MRdLk forwarded, target downstream port locked.
// - MRdLk waits for posted requests to port.
// - Downstream lock alone blocks no other port.
// - CplDLk locks upstream port, whole switch.
// - CplDLk waits for posted requests upstream.
// - Failed lock released by following Unlock.
// - Root ends every sequence with Unlock.
// - SMBus register access stays served while locked.
// - Root avoids switch configuration access while locked.
// - Locked traffic limited to MWr, MRdLk, Unlock.
// - Repeat MRdLk and completions keep lock state.
// - MWr to locked device keeps lock state.
// - Locked ports may still insert own messages.
// - Unlock unlocks, forwards Unlock, unblocks traffic.
// - Posted requests complete before leaving lock.
// - Blocked TLPs held until unlock.
// - Root sends nothing to unlocked ports while locked.
// - Lock mode flag shows switch lock.
package slc_pkg;

   // ----------------------------------------------------------------
   // Widths and reset values
   // ----------------------------------------------------------------
   localparam int          NUM_DN        = 2;
   localparam int          PORT_W        = 2;
   localparam logic [1:0]  LOCK_PORT_RST = 2'h0;

   // ----------------------------------------------------------------
   // Request and completion kinds
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SLC_MWR    = 3'h0,
      SLC_MRD    = 3'h1,
      SLC_CFG    = 3'h2,
      SLC_MRDLK  = 3'h3,
      SLC_UNLOCK = 3'h4,
      SLC_MSG    = 3'h5
   } slc_req_t;

   typedef enum logic [1:0] {
      SLC_CPL    = 2'h0,
      SLC_CPLD   = 2'h1,
      SLC_CPLLK  = 2'h2,
      SLC_CPLDLK = 2'h3
   } slc_cpl_t;

   // ----------------------------------------------------------------
   // Lock states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      SLC_ST_IDLE   = 4'h1,
      SLC_ST_DNLOCK = 4'h2,
      SLC_ST_SWLOCK = 4'h4,
      SLC_ST_FAIL   = 4'h8
   } slc_st_t;

endpackage

// ### logic/slc_link_if.sv
`timescale 1ns/1ps
interface slc_link_if;
   logic                        dn_valid;
   logic                        dn_ready;
   slc_pkg::slc_req_t           dn_type;
   logic [slc_pkg::PORT_W-1:0]  dn_port;
   logic                        up_valid;
   logic                        up_ready;
   slc_pkg::slc_cpl_t           up_type;
   logic [slc_pkg::PORT_W-1:0]  up_port;

   modport sw (
      input  dn_valid,
      input  dn_type,
      input  dn_port,
      output dn_ready,
      output up_valid,
      output up_type,
      output up_port,
      input  up_ready
   );

   modport rt (
      output dn_valid,
      output dn_type,
      output dn_port,
      input  dn_ready,
      input  up_valid,
      input  up_type,
      input  up_port,
      output up_ready
   );
endinterface

// ### logic/slc_root_end.sv
`timescale 1ns/1ps
module slc_root_end (
   input  wire logic                        clk_sys,
   input  wire logic                        srst,
   slc_link_if.rt                           lk,
   input  wire logic                        cmd_valid,
   output logic                             cmd_ready,
   input  wire slc_pkg::slc_req_t           cmd_type,
   input  wire logic [slc_pkg::PORT_W-1:0]  cmd_port,
   output logic                             cmd_reject,
   output logic                             cpl_valid,
   output slc_pkg::slc_cpl_t                cpl_type,
   output logic [slc_pkg::PORT_W-1:0]       cpl_port,
   output logic                             seq_active
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                         seq;
      logic [slc_pkg::PORT_W-1:0]   seq_port;
      logic                         cmd_ready;
      logic                         reject;
      logic                         dn_valid;
      slc_pkg::slc_req_t            dn_type;
      logic [slc_pkg::PORT_W-1:0]   dn_port;
      logic                         up_ready;
      logic                         cpl_valid;
      slc_pkg::slc_cpl_t            cpl_type;
      logic [slc_pkg::PORT_W-1:0]   cpl_port;
   } slc_root_t;

   slc_root_t  state_reg;
   slc_root_t  state_next;
   logic       legal;

   // ----------------------------------------------------------------
   // Legality of a command during a sequence
   // ----------------------------------------------------------------
   always_comb begin
      legal = 1'b1;
      if (state_reg.seq) begin
         legal = (cmd_port == state_reg.seq_port) &&
                 (cmd_type == slc_pkg::SLC_MWR || cmd_type == slc_pkg::SLC_MRDLK ||
                  cmd_type == slc_pkg::SLC_UNLOCK);
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next           = state_reg;
      state_next.reject    = 1'b0;
      state_next.cpl_valid = 1'b0;
      state_next.up_ready  = 1'b1;
      if (state_reg.dn_valid && lk.dn_ready) begin
         state_next.dn_valid = 1'b0;
      end
      if (cmd_valid && state_reg.cmd_ready) begin
         if (legal) begin
            state_next.dn_valid = 1'b1;
            state_next.dn_type  = cmd_type;
            state_next.dn_port  = cmd_port;
            if (cmd_type == slc_pkg::SLC_MRDLK && !state_reg.seq) begin
               state_next.seq      = 1'b1;
               state_next.seq_port = cmd_port;
            end
            if (cmd_type == slc_pkg::SLC_UNLOCK) begin
               state_next.seq = 1'b0;
            end
         end else begin
            state_next.reject = 1'b1;
         end
      end
      if (lk.up_valid && state_reg.up_ready) begin
         state_next.cpl_valid = 1'b1;
         state_next.cpl_type  = lk.up_type;
         state_next.cpl_port  = lk.up_port;
      end
      state_next.cmd_ready = !state_next.dn_valid;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign lk.dn_valid  = state_reg.dn_valid;
   assign lk.dn_type   = state_reg.dn_type;
   assign lk.dn_port   = state_reg.dn_port;
   assign lk.up_ready  = state_reg.up_ready;
   assign cmd_ready    = state_reg.cmd_ready;
   assign cmd_reject   = state_reg.reject;
   assign cpl_valid    = state_reg.cpl_valid;
   assign cpl_type     = state_reg.cpl_type;
   assign cpl_port     = state_reg.cpl_port;
   assign seq_active   = state_reg.seq;

endmodule // slc_root_end

// ### sim/slc_lock_props.sv
`timescale 1ns/1ps
module slc_lock_props #(
   parameter int NUM_DN = slc_pkg::NUM_DN
) (
   input logic                        clk_sys,
   input logic                        srst,
   input logic                        dn_valid,
   input logic                        dn_ready,
   input slc_pkg::slc_req_t           dn_type,
   input logic                        fwd_valid,
   input slc_pkg::slc_req_t           fwd_type,
   input logic [slc_pkg::PORT_W-1:0]  fwd_port,
   input logic [NUM_DN-1:0]           us_posted_pend,
   input logic [NUM_DN-1:0]           ds_posted_pend,
   input logic                        ds_cpl_valid,
   input logic                        ds_cpl_ready,
   input slc_pkg::slc_cpl_t           ds_cpl_type,
   input logic [slc_pkg::PORT_W-1:0]  ds_cpl_port,
   input logic                        up_valid,
   input slc_pkg::slc_cpl_t           up_type,
   input logic [slc_pkg::PORT_W-1:0]  up_port,
   input logic [NUM_DN-1:0]           blk_dn_port,
   input logic                        blk_to_up,
   input logic [slc_pkg::PORT_W-1:0]  locked_port,
   input logic                        switch_locked_flag
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic                dn_tk;
   logic                cp_tk;
   logic [NUM_DN-1:0]   usp_reg;
   logic [NUM_DN-1:0]   dsp_reg;
   assign dn_tk = dn_valid && dn_ready;
   assign cp_tk = ds_cpl_valid && ds_cpl_ready;
   always_ff @(posedge clk_sys) begin
      usp_reg <= us_posted_pend;
      dsp_reg <= ds_posted_pend;
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   property p_one_lock; $onehot0(blk_dn_port); endproperty
   a_one_lock: assert property (p_one_lock)
      else $error("more than one port locked");
   property p_mrdlk;
      dn_tk && dn_type == slc_pkg::SLC_MRDLK && blk_dn_port == '0 |-> ##[1:60]
         (fwd_valid && fwd_type == slc_pkg::SLC_MRDLK && blk_dn_port[fwd_port]);
   endproperty
   a_mrdlk: assert property (p_mrdlk)
      else $error("locked read not forwarded with port lock");
   property p_mrd_post;
      $rose(fwd_valid) && fwd_type == slc_pkg::SLC_MRDLK |-> !usp_reg[fwd_port];
   endproperty
   a_mrd_post: assert property (p_mrd_post)
      else $error("locked read passed posted requests");
   property p_dn_only;
      |blk_dn_port && !blk_to_up |-> blk_dn_port == (NUM_DN'(1) << locked_port);
   endproperty
   a_dn_only: assert property (p_dn_only)
      else $error("other port blocked by downstream lock");
   property p_cpldlk;
      cp_tk && ds_cpl_type == slc_pkg::SLC_CPLDLK && !blk_to_up && blk_dn_port[ds_cpl_port]
         |-> ##[1:60] (switch_locked_flag && blk_to_up && up_valid);
   endproperty
   a_cpldlk: assert property (p_cpldlk)
      else $error("switch not locked by locked completion");
   property p_cpl_post;
      $rose(up_valid) && up_type == slc_pkg::SLC_CPLDLK |-> !dsp_reg[up_port];
   endproperty
   a_cpl_post: assert property (p_cpl_post)
      else $error("locked completion passed posted requests");
   property p_fail;
      cp_tk && ds_cpl_type == slc_pkg::SLC_CPLLK && !blk_to_up && blk_dn_port[ds_cpl_port]
         |-> ##[1:60] (blk_to_up && !switch_locked_flag);
   endproperty
   a_fail: assert property (p_fail)
      else $error("failed lock not held until unlock");
   property p_keep;
      switch_locked_flag && dn_tk && dn_type != slc_pkg::SLC_UNLOCK |=> switch_locked_flag [*2];
   endproperty
   a_keep: assert property (p_keep)
      else $error("lock lost without unlock");
   property p_unlock;
      dn_tk && dn_type == slc_pkg::SLC_UNLOCK && blk_to_up |-> ##[1:60] (fwd_valid &&
         fwd_type == slc_pkg::SLC_UNLOCK && blk_dn_port == '0 && !blk_to_up && !switch_locked_flag);
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("unlock did not release switch");
   property p_unl_post; $fell(blk_to_up) |-> usp_reg == '0; endproperty
   a_unl_post: assert property (p_unl_post)
      else $error("unlock passed posted requests");
   c_swlock: cover property ($rose(switch_locked_flag));
   c_fail: cover property (blk_to_up && !switch_locked_flag);
   c_unlock: cover property (fwd_valid && fwd_type == slc_pkg::SLC_UNLOCK);
endmodule // slc_lock_props

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic                clk_sys, srst, cmd_valid, cmd_ready, cmd_reject, cpl_valid, seq_active;
   logic                fwd_valid, fwd_ready, ds_cpl_valid, ds_cpl_ready;
   logic                blk_to_up, up_lock_held, switch_locked_flag;
   logic [1:0]          us_posted_pend, ds_posted_pend, blk_dn_port;
   logic [1:0]          cmd_port, cpl_port, fwd_port, ds_cpl_port, locked_port;
   slc_pkg::slc_req_t   cmd_type, fwd_type;
   slc_pkg::slc_cpl_t   cpl_type, ds_cpl_type;
   logic [31:0]         rnd;
   logic [4:0]          q_fwd[$], q_cpl[$];
   int                  n_fail, num_checks;
   // ---------------------------------------------------------------
   // Design and checker
   // ---------------------------------------------------------------
   slc_link_if lk ();
   slc_switch_lock #(.NUM_DN(2)) i_slc_switch_lock (.clk_sys(clk_sys), .srst(srst), .lk(lk),
      .us_posted_pend(us_posted_pend), .ds_posted_pend(ds_posted_pend), .fwd_valid(fwd_valid),
      .fwd_ready(fwd_ready), .fwd_type(fwd_type), .fwd_port(fwd_port),
      .ds_cpl_valid(ds_cpl_valid), .ds_cpl_ready(ds_cpl_ready), .ds_cpl_type(ds_cpl_type),
      .ds_cpl_port(ds_cpl_port), .blk_dn_port(blk_dn_port), .blk_to_up(blk_to_up),
      .up_lock_held(up_lock_held), .locked_port(locked_port),
      .switch_locked_flag(switch_locked_flag));
   slc_root_end i_slc_root_end (.clk_sys(clk_sys), .srst(srst), .lk(lk), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_type(cmd_type), .cmd_port(cmd_port), .cmd_reject(cmd_reject),
      .cpl_valid(cpl_valid), .cpl_type(cpl_type), .cpl_port(cpl_port), .seq_active(seq_active));
   slc_lock_props #(.NUM_DN(2)) i_slc_lock_props (.clk_sys(clk_sys), .srst(srst),
      .dn_valid(lk.dn_valid), .dn_ready(lk.dn_ready), .dn_type(lk.dn_type),
      .fwd_valid(fwd_valid), .fwd_type(fwd_type), .fwd_port(fwd_port),
      .us_posted_pend(us_posted_pend), .ds_posted_pend(ds_posted_pend),
      .ds_cpl_valid(ds_cpl_valid), .ds_cpl_ready(ds_cpl_ready), .ds_cpl_type(ds_cpl_type),
      .ds_cpl_port(ds_cpl_port), .up_valid(lk.up_valid), .up_type(lk.up_type),
      .up_port(lk.up_port), .blk_dn_port(blk_dn_port), .blk_to_up(blk_to_up),
      .locked_port(locked_port), .switch_locked_flag(switch_locked_flag));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic wt(ref logic s);
      for (int i = 0; i < 300 && s !== 1'h1; i++) begin
         @(posedge clk_sys) #1;
      end
      if (s !== 1'h1) begin
         n_fail++;
         test_done;
      end
   endtask
   task automatic send(input slc_pkg::slc_req_t t, input logic [1:0] p, input logic rej);
      logic rj;
      rj = 1'h0;
      cmd_type = t;
      cmd_port = p;
      cmd_valid = 1'h1;
      wt(cmd_ready);
      @(posedge clk_sys) #1;
      cmd_valid = 1'h0;
      if (!rej) q_fwd.push_back({t, p});
      repeat (3) begin
         rj = rj | cmd_reject;
         @(posedge clk_sys) #1;
      end
      chk("cmd_reject", rj, rej);
   endtask
   task automatic cpl(input slc_pkg::slc_cpl_t t, input logic [1:0] p);
      ds_cpl_type = t;
      ds_cpl_port = p;
      ds_cpl_valid = 1'h1;
      wt(ds_cpl_ready);
      @(posedge clk_sys) #1;
      ds_cpl_valid = 1'h0;
      q_cpl.push_back({1'h0, t, p});
      @(posedge clk_sys) #1;
   endtask
   task automatic drain;
      int i;
      for (i = 0; i < 300 && (q_fwd.size() + q_cpl.size()) > 0; i++) begin
         @(posedge clk_sys) #1;
      end
      if (i == 300) begin
         n_fail++;
         test_done;
      end
      @(posedge clk_sys) #1;
   endtask
   task automatic st(input logic [1:0] b, input logic u, input logic f);
      chk("blk_dn_port", blk_dn_port, b);
      chk("blk_to_up", blk_to_up, u);
      chk("switch_locked_flag", switch_locked_flag, f);
      chk("up_lock_held", up_lock_held, u);
      chk("locked_port", locked_port, {7'h0, b[1]});
      chk("seq_active", seq_active, |b);
   endtask
   // ---------------------------------------------------------------
   // Clock, random inputs and result monitor
   // ---------------------------------------------------------------
   initial begin
      clk_sys = 1'h0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      #1;
      rnd = xs(rnd);
      fwd_ready = rnd[0];
      us_posted_pend = rnd[2:1] & {2{rnd[3]}};
      ds_posted_pend = rnd[5:4] & {2{rnd[6]}};
   end
   always @(posedge clk_sys) begin
      if (!srst && fwd_valid && fwd_ready) begin
         chk("fwd", {fwd_type, fwd_port}, q_fwd.size() ? q_fwd.pop_front() : 8'hFF);
      end
      if (!srst && cpl_valid) begin
         chk("cpl", {cpl_type, cpl_port}, q_cpl.size() ? q_cpl.pop_front() : 8'hFF);
      end
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rnd = 32'h2;
      srst = 1'h1;
      cmd_valid = 1'h0;
      cmd_type = slc_pkg::SLC_MWR;
      cmd_port = 2'h0;
      ds_cpl_valid = 1'h0;
      ds_cpl_type = slc_pkg::SLC_CPL;
      ds_cpl_port = 2'h0;
      fwd_ready = 1'h0;
      us_posted_pend = 2'h0;
      ds_posted_pend = 2'h0;
      n_fail = 0;
      num_checks = 0;
      repeat (10) @(posedge clk_sys);
      #1 srst = 1'h0;
      st(2'h0, 1'h0, 1'h0);
      chk("locked_port", locked_port, 8'h0);
      send(slc_pkg::SLC_MWR, 2'h0, 1'h0);
      send(slc_pkg::SLC_MRDLK, 2'h1, 1'h0);
      drain;
      st(2'h2, 1'h0, 1'h0);
      cpl(slc_pkg::SLC_CPLDLK, 2'h1);
      drain;
      st(2'h2, 1'h1, 1'h1);
      send(slc_pkg::SLC_MWR, 2'h1, 1'h0);
      send(slc_pkg::SLC_MRDLK, 2'h1, 1'h0);
      cpl(slc_pkg::SLC_CPLLK, 2'h1);
      drain;
      st(2'h2, 1'h1, 1'h1);
      send(slc_pkg::SLC_MRD, 2'h1, 1'h1);
      send(slc_pkg::SLC_MWR, 2'h0, 1'h1);
      send(slc_pkg::SLC_CFG, 2'h1, 1'h1);
      send(slc_pkg::SLC_UNLOCK, 2'h1, 1'h0);
      drain;
      st(2'h0, 1'h0, 1'h0);
      for (int p = 0; p < 2; p++) begin
         send(slc_pkg::SLC_MRDLK, 2'(p), 1'h0);
         drain;
         cpl(slc_pkg::SLC_CPLLK, 2'(p));
         drain;
         st(2'h1 << p, 1'h1, 1'h0);
         send(slc_pkg::SLC_UNLOCK, 2'(p), 1'h0);
         drain;
         st(2'h0, 1'h0, 1'h0);
      end
      test_done;
   end
endmodule // tb_top
